// ==== logic/mode_handler_defines.svh ====
`ifndef MODE_HANDLER_DEFINES_SVH
`define MODE_HANDLER_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CONFIG 6'h00
`define OFS_STATUS 6'h04
`define OFS_DESC_VEC 6'h08
`define OFS_DESC_SYNC 6'h0c
`define OFS_INFO_VEC 6'h10
`define OFS_INFO_SYNC 6'h14
`define OFS_WORD4_VEC 6'h18
`define OFS_WORD4_SYNC 6'h1c
`define OFS_BUF_VEC0 6'h20
`define OFS_BUF_VEC1 6'h24
`define OFS_BUF_SYNC0 6'h28
`define OFS_BUF_SYNC1 6'h2c
`define OFS_TIMETAG 6'h30
`define OFS_INT_STATUS 6'h34
`define OFS_INT_MASK 6'h38

// ----------------------------------------
// config fields, reset values
// ----------------------------------------
`define CFG_UNDEF_INV 0
`define CFG_TT_EVEN 1
`define CFG_TT_ODD 2
`define CFG_SIMPLE 3
`define CFG_ILL_VEC 4
`define CFG_ILL_SYNC 5
`define CFG_ADDR_LSB 6
`define CFG_ADDR_MSB 10
`define CONFIG_RESET 16'h0000
`define MASK_RESET 4'h0

// ----------------------------------------
// command and status word layout
// ----------------------------------------
`define MC_VECTOR 5'h10
`define MC_SYNC 5'h11
`define BROADCAST_DESCRIPTOR_FLAG_ADDR 5'h1f
`define SUBADDR_MODE_A 5'h00
`define SUBADDR_MODE_B 5'h1f
`define ST_ME 10
`define ST_BCR 4

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define INT_WORD_ACC 0
`define INT_BROADCAST 1
`define INT_MSG_ERR 2
`define INT_ILLEGAL 3

`endif

// ==== logic/mode_handler_pkg.sv ====
package mode_handler_pkg;

    // word from the bus decoder
    typedef struct packed {
        logic valid;
        logic is_cmd;
        logic bad;
        logic [15:0] word;
    } rx_word_t;

    // descriptor control word flags
    typedef struct packed {
        logic ping_pong_selector;
        logic broadcast_descriptor_flag;
        logic data_block_accessed_flag;
    } desc_t;

    // message info word flags
    typedef struct packed {
        logic word_count_error_flag;
        logic terminal_to_terminal_flag;
        logic illegal_command_flag;
        logic message_error_flag;
        logic receiving_bus_identifier;
    } info_t;

    // message in progress
    typedef struct packed {
        logic vec;
        logic bc;
        logic tr;
        logic ill;
        logic simple;
        logic bus;
        logic got;
        logic bad;
        logic send_data;
        logic [15:0] data;
    } msg_t;

    typedef enum logic [1:0] {IDLE, COLLECT, SEND_STATUS, SEND_DATA} state_t;

endpackage

// ==== logic/mode_handler.sv ====
// The register addresses and the Avalon-MM slave port were left to the implementer.
`include "mode_handler_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module mode_handler (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire mode_handler_pkg::rx_word_t RX,
    input wire logic RX_END,
    input wire logic RX_BUS,
    input wire logic TT_TICK,
    output logic TX_VALID,
    output logic [15:0] TX_WORD,
    input wire logic TX_READY,
    output logic IRQ
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    mode_handler_pkg::state_t state_q, state_d;
    mode_handler_pkg::msg_t msg_q, msg_d;
    mode_handler_pkg::desc_t desc_q [2];
    mode_handler_pkg::desc_t desc_d [2];
    mode_handler_pkg::info_t info_q [2];
    mode_handler_pkg::info_t info_d [2];
    logic [15:0] cfg_q, cfg_d;
    logic [15:0] word4_q [2];
    logic [15:0] word4_d [2];
    logic [15:0] buf_q [4];
    logic [15:0] buf_d [4];
    logic [15:0] tt_q, tt_d;
    logic me_q, me_d;
    logic bcr_q, bcr_d;
    logic [3:0] ints_q, ints_d;
    logic [3:0] mask_q, mask_d;
    logic [3:0] ev;
    logic irq_q, irq_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic tx_valid_q, tx_valid_d;
    logic [15:0] tx_word_q, tx_word_d;
    logic accept;
    logic [15:0] wmask;
    logic [15:0] rd_word;
    logic [15:0] sw;
    logic [4:0] rt_addr;
    logic hit;
    logic errwc;
    logic idx;

    assign rt_addr = cfg_q[`CFG_ADDR_MSB:`CFG_ADDR_LSB];
    assign wmask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

    // ----------------------------------------
    // register read mux
    // ----------------------------------------
    // unmapped offsets read as zero
    always_comb begin
        case (AVS_ADDRESS)
            `OFS_CONFIG: rd_word = cfg_q;
            `OFS_STATUS: rd_word = {rt_addr, me_q, 5'h00, bcr_q, 4'h0};
            `OFS_DESC_VEC: rd_word = {13'h0000, desc_q[0]};
            `OFS_DESC_SYNC: rd_word = {13'h0000, desc_q[1]};
            `OFS_INFO_VEC: rd_word = {11'h000, info_q[0]};
            `OFS_INFO_SYNC: rd_word = {11'h000, info_q[1]};
            `OFS_WORD4_VEC: rd_word = word4_q[0];
            `OFS_WORD4_SYNC: rd_word = word4_q[1];
            `OFS_BUF_VEC0: rd_word = buf_q[0];
            `OFS_BUF_VEC1: rd_word = buf_q[1];
            `OFS_BUF_SYNC0: rd_word = buf_q[2];
            `OFS_BUF_SYNC1: rd_word = buf_q[3];
            `OFS_TIMETAG: rd_word = tt_q;
            `OFS_INT_STATUS: rd_word = {12'h000, ints_q};
            `OFS_INT_MASK: rd_word = {12'h000, mask_q};
            default: rd_word = 16'h0000;
        endcase
    end

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    // one wait cycle per access, answer on the second
    always_comb begin
        state_d = state_q;
        msg_d = msg_q;
        desc_d = desc_q;
        info_d = info_q;
        cfg_d = cfg_q;
        word4_d = word4_q;
        buf_d = buf_q;
        tt_d = tt_q + {15'h0000, TT_TICK};
        me_d = me_q;
        bcr_d = bcr_q;
        ints_d = ints_q;
        mask_d = mask_q;
        tx_valid_d = tx_valid_q;
        tx_word_d = tx_word_q;
        ev = 4'h0;
        hit = 1'b0;
        errwc = 1'b0;
        idx = msg_q.vec ? 1'b0 : 1'b1;
        sw = 16'h0000;
        wait_d = ~((AVS_READ | AVS_WRITE) & wait_q);
        accept = (AVS_READ | AVS_WRITE) & ~wait_q;
        rdata_d = rdata_q;
        if (!wait_d) begin
            rdata_d = {16'h0000, rd_word};
        end

        // software writes
        if (accept && AVS_WRITE) begin
            case (AVS_ADDRESS)
                `OFS_CONFIG: cfg_d = (cfg_q & ~wmask) | (AVS_WRITEDATA[15:0] & wmask);
                `OFS_WORD4_VEC: word4_d[0] = (word4_q[0] & ~wmask) | (AVS_WRITEDATA[15:0] & wmask);
                `OFS_WORD4_SYNC: word4_d[1] = (word4_q[1] & ~wmask) | (AVS_WRITEDATA[15:0] & wmask);
                `OFS_BUF_VEC0: buf_d[0] = (buf_q[0] & ~wmask) | (AVS_WRITEDATA[15:0] & wmask);
                `OFS_BUF_VEC1: buf_d[1] = (buf_q[1] & ~wmask) | (AVS_WRITEDATA[15:0] & wmask);
                `OFS_BUF_SYNC0: buf_d[2] = (buf_q[2] & ~wmask) | (AVS_WRITEDATA[15:0] & wmask);
                `OFS_BUF_SYNC1: buf_d[3] = (buf_q[3] & ~wmask) | (AVS_WRITEDATA[15:0] & wmask);
                `OFS_INT_MASK: begin
                    if (AVS_BYTEENABLE[0]) begin
                        mask_d = AVS_WRITEDATA[3:0];
                    end
                end
                default: ;
            endcase
        end
        if (accept && AVS_READ && AVS_ADDRESS == `OFS_INT_STATUS) begin
            ints_d = ints_q & ~rdata_q[3:0]; // unread bits stay
        end

        // message sequencer
        case (state_q)
            mode_handler_pkg::IDLE: begin
                if (RX.valid && RX.is_cmd && !RX.bad) begin
                    hit = (RX.word[15:11] == rt_addr || RX.word[15:11] == `BROADCAST_DESCRIPTOR_FLAG_ADDR)
                        && (RX.word[9:5] == `SUBADDR_MODE_A || RX.word[9:5] == `SUBADDR_MODE_B)
                        && (RX.word[4:0] == `MC_VECTOR || RX.word[4:0] == `MC_SYNC);
                    // invalid words never reach here; undefined receive is dropped
                    if (hit && !(!RX.word[10] && cfg_q[`CFG_UNDEF_INV])) begin
                        msg_d.vec = RX.word[4:0] == `MC_VECTOR;
                        msg_d.bc = RX.word[15:11] == `BROADCAST_DESCRIPTOR_FLAG_ADDR;
                        msg_d.tr = RX.word[10];
                        msg_d.ill = (RX.word[4:0] == `MC_VECTOR) ? cfg_q[`CFG_ILL_VEC]
                                                                : cfg_q[`CFG_ILL_SYNC];
                        msg_d.simple = cfg_q[`CFG_SIMPLE]; // held for the message
                        msg_d.bus = RX_BUS;
                        msg_d.got = 1'b0;
                        msg_d.bad = 1'b0;
                        msg_d.send_data = 1'b0;
                        msg_d.data = 16'h0000;
                        state_d = mode_handler_pkg::COLLECT;
                    end
                end
            end
            mode_handler_pkg::COLLECT: begin
                if (RX.valid && RX.is_cmd) begin
                    state_d = mode_handler_pkg::IDLE; // superseded by a new command, no update
                end else if (RX.valid) begin
                    msg_d.got = 1'b1;
                    msg_d.bad = msg_q.bad | RX.bad | msg_q.got;
                    if (!msg_q.vec && msg_q.tr && !msg_q.got && !RX.bad) begin
                        msg_d.data = RX.word;
                        if (msg_q.simple) begin
                            word4_d[1] = RX.word;
                        end else begin
                            buf_d[{1'b1, desc_q[1].ping_pong_selector}] = RX.word;
                        end
                    end
                end else if (RX_END) begin
                    // common update: bus id, clean info, toggle buffer
                    info_d[idx] = '0;
                    info_d[idx].receiving_bus_identifier = msg_q.bus;
                    desc_d[idx].ping_pong_selector = ~desc_q[idx].ping_pong_selector;
                    ev[`INT_WORD_ACC] = 1'b1;
                    errwc = (msg_q.vec || !msg_q.tr) ? msg_q.got : (!msg_q.got || msg_q.bad);
                    if (errwc) begin
                        // unexpected or missing data word
                        me_d = 1'b1;
                        bcr_d = msg_q.bc;
                        desc_d[idx].data_block_accessed_flag = 1'b1;
                        desc_d[idx].broadcast_descriptor_flag = 1'b0;
                        info_d[idx].message_error_flag = 1'b1;
                        info_d[idx].word_count_error_flag = 1'b1;
                        ev[`INT_MSG_ERR] = 1'b1;
                        ev[`INT_BROADCAST] = msg_q.bc;
                    end else if (msg_q.vec && msg_q.tr && msg_q.bc) begin
                        // vector may not be broadcast
                        me_d = 1'b1;
                        bcr_d = 1'b1;
                        desc_d[0].data_block_accessed_flag = 1'b1;
                        desc_d[0].broadcast_descriptor_flag = 1'b1;
                        info_d[0].message_error_flag = 1'b1;
                        ev[`INT_MSG_ERR] = 1'b1;
                        ev[`INT_BROADCAST] = 1'b1;
                    end else if (!msg_q.tr) begin
                        // receive direction, in form or illegal
                        me_d = msg_q.ill;
                        bcr_d = msg_q.bc;
                        desc_d[idx].data_block_accessed_flag = 1'b1;
                        desc_d[idx].broadcast_descriptor_flag = msg_q.bc;
                        info_d[idx].message_error_flag = msg_q.ill;
                        info_d[idx].illegal_command_flag = msg_q.ill;
                        ev[`INT_ILLEGAL] = msg_q.ill;
                        ev[`INT_BROADCAST] = msg_q.bc;
                        msg_d.send_data = 1'b0;
                        hit = !msg_q.bc;
                    end else if (msg_q.vec) begin
                        me_d = 1'b0;
                        bcr_d = 1'b0;
                        desc_d[0].data_block_accessed_flag = 1'b0;
                        desc_d[0].broadcast_descriptor_flag = 1'b0;
                        msg_d.send_data = 1'b1;
                        msg_d.data = msg_q.simple ? word4_q[0]
                                                  : buf_q[{1'b0, desc_q[0].ping_pong_selector}];
                        hit = 1'b1;
                    end else begin
                        me_d = 1'b0;
                        bcr_d = msg_q.bc;
                        desc_d[1].data_block_accessed_flag = 1'b0;
                        desc_d[1].broadcast_descriptor_flag = 1'b0;
                        msg_d.send_data = 1'b0;
                        hit = !msg_q.bc;
                        // loaded here, on the same edge that raises TX_VALID for the status word; a broadcast loads it with no status word sent
                        if ((cfg_q[`CFG_TT_EVEN] && !msg_q.data[0])
                            || (cfg_q[`CFG_TT_ODD] && msg_q.data[0])) begin
                            tt_d = msg_q.data;
                        end
                    end
                    sw[15:11] = rt_addr;
                    sw[`ST_ME] = me_d;
                    sw[`ST_BCR] = bcr_d;
                    if (hit && !errwc) begin
                        tx_valid_d = 1'b1;
                        tx_word_d = sw;
                        state_d = mode_handler_pkg::SEND_STATUS;
                    end else begin
                        state_d = mode_handler_pkg::IDLE;
                    end
                end
            end
            mode_handler_pkg::SEND_STATUS: begin
                if (TX_READY) begin
                    if (msg_q.send_data) begin
                        tx_word_d = msg_q.data;
                        state_d = mode_handler_pkg::SEND_DATA;
                    end else begin
                        tx_valid_d = 1'b0;
                        state_d = mode_handler_pkg::IDLE;
                    end
                end
            end
            mode_handler_pkg::SEND_DATA: begin
                if (TX_READY) begin
                    tx_valid_d = 1'b0;
                    state_d = mode_handler_pkg::IDLE;
                end
            end
            default: state_d = mode_handler_pkg::IDLE;
        endcase

        // a new event wins over a read clear
        ints_d = ints_d | ev;
        irq_d = |(ints_d & mask_d);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= mode_handler_pkg::IDLE;
            msg_q <= '0;
            cfg_q <= `CONFIG_RESET;
            tt_q <= 16'h0000;
            me_q <= 1'b0;
            bcr_q <= 1'b0;
            ints_q <= 4'h0;
            mask_q <= `MASK_RESET;
            irq_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            tx_valid_q <= 1'b0;
            tx_word_q <= 16'h0000;
            for (int i = 0; i < 2; i++) begin
                desc_q[i] <= '0;
                info_q[i] <= '0;
                word4_q[i] <= 16'h0000;
            end
            for (int i = 0; i < 4; i++) begin
                buf_q[i] <= 16'h0000;
            end
        end else begin
            state_q <= state_d;
            msg_q <= msg_d;
            cfg_q <= cfg_d;
            tt_q <= tt_d;
            me_q <= me_d;
            bcr_q <= bcr_d;
            ints_q <= ints_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            tx_valid_q <= tx_valid_d;
            tx_word_q <= tx_word_d;
            desc_q <= desc_d;
            info_q <= info_d;
            word4_q <= word4_d;
            buf_q <= buf_d;
        end
    end

    assign AVS_READDATA = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign TX_VALID = tx_valid_q;
    assign TX_WORD = tx_word_q;
    assign IRQ = irq_q;

endmodule // mode_handler

`default_nettype wire

// ==== tb/mode_handler_assertions.sv ====
`include "mode_handler_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module mode_handler_assertions (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire mode_handler_pkg::rx_word_t RX,
    input wire logic RX_END,
    input wire logic TX_VALID,
    input wire logic [15:0] TX_WORD,
    input wire logic TX_READY,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // shadow of the interrupt mask, taken from completed writes
    logic [3:0] mask_q;
    logic [3:0] mask_d;
    always_comb begin
        mask_d = mask_q;
        if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `OFS_INT_MASK && AVS_BYTEENABLE[0]) begin
            mask_d = AVS_WRITEDATA[3:0];
        end
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mask_q <= 4'h0;
        end else begin
            mask_q <= mask_d;
        end
    end
    // --------------------------------
    // properties
    // --------------------------------
    chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("waitrequest stayed high");
    chk_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low too long");
    chk_rdata_upper: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    chk_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_WORD))
        else $error("tx word dropped before taken");
    chk_tx_after_end: assert property ($rose(TX_VALID) |-> $past(RX_END))
        else $error("status not one cycle after message end");
    chk_status_fields: assert property ($rose(TX_VALID) |-> (TX_WORD & 16'h03ef) == 16'h0000)
        else $error("status word has stray bits");
    chk_bad_silent: assert property (RX.valid && RX.is_cmd && RX.bad && !TX_VALID |=> !TX_VALID [*8])
        else $error("answer to invalid command");
    chk_irq_masked: assert property (IRQ |-> (mask_q != 4'h0 || $past(mask_q) != 4'h0))
        else $error("interrupt with all sources masked");
endmodule // mode_handler_assertions

bind mode_handler mode_handler_assertions i_chk (.CLK(CLK), .RST_N(RST_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .RX(RX), .RX_END(RX_END), .TX_VALID(TX_VALID),
    .TX_WORD(TX_WORD), .TX_READY(TX_READY), .IRQ(IRQ));
`default_nettype wire

// ==== tb/bc_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module bc_model (
    input wire logic CLK,
    output var mode_handler_pkg::rx_word_t RX,
    output logic RX_END,
    output logic RX_BUS,
    output logic TX_READY,
    input wire logic TX_VALID,
    input wire logic [15:0] TX_WORD
);
    logic slow;
    logic [15:0] txq[$];
    initial begin
        RX = '0;
        RX_END = 1'b0;
        RX_BUS = 1'b0;
        TX_READY = 1'b1;
        slow = 1'b0;
    end
    // a slow encoder only takes every other slot, so the terminal must hold
    always @(posedge CLK) begin
        TX_READY <= slow ? ~TX_READY : 1'b1;
        if (TX_VALID && TX_READY) begin
            txq.push_back(TX_WORD);
        end
    end
    // command, nd contiguous data words, then bus quiet
    task automatic msg(input logic [15:0] cmd, input logic bad, input logic bus, input int nd,
                       input logic [15:0] d);
        @(posedge CLK);
        RX <= '{1'b1, 1'b1, bad, cmd};
        RX_BUS <= bus;
        for (int i = 0; i < nd; i++) begin
            @(posedge CLK);
            RX <= '{1'b1, 1'b0, 1'b0, d};
        end
        @(posedge CLK);
        RX <= '{1'b0, 1'b0, 1'b0, ~RX.word}; // no stale word left on the idle bus
        RX_END <= 1'b1;
        @(posedge CLK);
        RX_END <= 1'b0;
    endtask
endmodule // bc_model
`default_nettype wire

// ==== tb/testbench.sv ====
`include "mode_handler_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk;
    logic rst_n;
    logic [5:0] adr;
    logic rd_en;
    logic wr_en;
    logic [31:0] wdat;
    logic [31:0] rd_data;
    logic [31:0] rdat;
    logic wreq;
    logic irq;
    logic tx_valid;
    logic [15:0] tx_word;
    logic tx_ready;
    logic rx_end;
    logic rx_bus;
    logic tt_tick;
    logic ppv;
    logic pps;
    logic [15:0] tt;
    mode_handler_pkg::rx_word_t rx;
    int error_cnt;
    int total_checks;
    int cyc;
    mode_handler i_dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
        .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rd_data),
        .AVS_WAITREQUEST(wreq), .RX(rx), .RX_END(rx_end), .RX_BUS(rx_bus), .TT_TICK(tt_tick),
        .TX_VALID(tx_valid), .TX_WORD(tx_word), .TX_READY(tx_ready), .IRQ(irq));
    bc_model i_bc (.CLK(clk), .RX(rx), .RX_END(rx_end), .RX_BUS(rx_bus), .TX_READY(tx_ready),
        .TX_VALID(tx_valid), .TX_WORD(tx_word));
    // --------------------------------
    // helpers
    // --------------------------------
    task automatic stop_test();
        if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= {16'h0000, d};
        wr_en <= w;
        rd_en <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        rdat = rd_data;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        chk({31'h0, wreq}, 32'h0);
    endtask
    task automatic rc(input logic [5:0] a, input logic [15:0] m, input logic [15:0] e);
        acc(1'b0, a, 16'h0000);
        chk(rdat & {16'h0000, m}, {16'h0000, e});
    endtask
    // the answer window is long enough for a slow encoder
    task automatic tx_chk(input int n, input logic [15:0] w0, input logic [15:0] w1);
        repeat (14) @(posedge clk);
        chk(32'(i_bc.txq.size()), 32'(n));
        if (n > 0) chk({16'h0, i_bc.txq[0]}, {16'h0, w0});
        if (n > 1) chk({16'h0, i_bc.txq[1]}, {16'h0, w1});
        i_bc.txq.delete();
    endtask
    function automatic logic [15:0] cw(input logic [4:0] a, input logic tr, input logic [4:0] mc);
        return {a, tr, 5'h00, mc};
    endfunction
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic s_regs();
        for (int a = 0; a < 64; a += 4) rc(6'(a), 16'hffff, 16'h0000);
        acc(1'b1, `OFS_STATUS, 16'hffff);
        rc(`OFS_STATUS, 16'hffff, 16'h0000);
        acc(1'b1, 6'h3c, 16'h1234);
        rc(6'h3c, 16'hffff, 16'h0000);
        acc(1'b1, `OFS_CONFIG, 16'h0140);
        rc(`OFS_CONFIG, 16'hffff, 16'h0140);
    endtask
    task automatic s_vec();
        acc(1'b1, `OFS_BUF_VEC0, 16'h1111);
        acc(1'b1, `OFS_BUF_VEC1, 16'h2222);
        acc(1'b1, `OFS_WORD4_VEC, 16'h3333);
        for (int i = 0; i < 3; i++) begin
            if (i == 2) acc(1'b1, `OFS_CONFIG, 16'h0148);
            i_bc.slow <= (i == 1);
            i_bc.msg(cw(5'h05, 1'b1, `MC_VECTOR), 1'b0, i[0], 0, 16'h0000);
            tx_chk(2, 16'h2800, 16'(16'h1111 * (i + 1)));
            chk({31'h0, irq}, 32'h0);
            ppv = ~ppv;
            rc(`OFS_DESC_VEC, 16'hffff, {13'h0, ppv, 2'b00});
            rc(`OFS_INFO_VEC, 16'hffff, {15'h0, i[0]});
            rc(`OFS_INT_STATUS, 16'hffff, 16'h0001);
            rc(`OFS_STATUS, 16'h0410, 16'h0000);
        end
    endtask
    task automatic s_vbc();
        acc(1'b1, `OFS_INT_MASK, 16'h0004);
        i_bc.msg(cw(`BROADCAST_DESCRIPTOR_FLAG_ADDR, 1'b1, `MC_VECTOR), 1'b0, 1'b1, 0, 16'h0000);
        tx_chk(0, 16'h0000, 16'h0000);
        chk({31'h0, irq}, 32'h1);
        ppv = ~ppv;
        rc(`OFS_STATUS, 16'h0410, 16'h0410);
        rc(`OFS_DESC_VEC, 16'hffff, {13'h0, ppv, 2'b11});
        rc(`OFS_INFO_VEC, 16'hffff, 16'h0003);
        rc(`OFS_INT_STATUS, 16'hffff, 16'h0007);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        acc(1'b1, `OFS_INT_MASK, 16'h0000);
    endtask
    task automatic s_ign();
        i_bc.msg(cw(5'h05, 1'b1, `MC_VECTOR), 1'b1, 1'b0, 0, 16'h0000);
        acc(1'b1, `OFS_CONFIG, 16'h0141);
        i_bc.msg(cw(5'h05, 1'b0, `MC_VECTOR), 1'b0, 1'b0, 0, 16'h0000);
        tx_chk(0, 16'h0000, 16'h0000);
        rc(`OFS_DESC_VEC, 16'hffff, {13'h0, ppv, 2'b11});
        rc(`OFS_INFO_VEC, 16'hffff, 16'h0003);
        rc(`OFS_INT_STATUS, 16'hffff, 16'h0000);
        rc(`OFS_STATUS, 16'h0410, 16'h0410);
    endtask
    // receive direction: bit 0 of i is broadcast, bit 1 is illegalized
    task automatic s_rxd();
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, `OFS_CONFIG, {5'h00, 5'h05, 1'b0, i[1], 4'h0});
            i_bc.msg(cw(i[0] ? `BROADCAST_DESCRIPTOR_FLAG_ADDR : 5'h05, 1'b0, `MC_VECTOR), 1'b0, 1'b1, 0, 16'h0000);
            tx_chk(i[0] ? 0 : 1, {5'h05, i[1], 10'h000}, 16'h0000);
            ppv = ~ppv;
            rc(`OFS_DESC_VEC, 16'hffff, {13'h0, ppv, i[0], 1'b1});
            rc(`OFS_INFO_VEC, 16'hffff, {13'h0, i[1], i[1], 1'b1});
            rc(`OFS_INT_STATUS, 16'hffff, {12'h0, i[1], 1'b0, i[0], 1'b1});
            rc(`OFS_STATUS, {5'h0, 1'b1, 5'h0, i[0], 4'h0}, {5'h0, i[1], 5'h0, i[0], 4'h0});
        end
    endtask
    task automatic s_vex();
        acc(1'b1, `OFS_CONFIG, 16'h0140);
        i_bc.msg(cw(5'h05, 1'b1, `MC_VECTOR), 1'b0, 1'b0, 1, 16'hbeef);
        tx_chk(0, 16'h0000, 16'h0000);
        rc(`OFS_DESC_VEC, 16'h0003, 16'h0001);
        rc(`OFS_INFO_VEC, 16'hffff, 16'h0012);
        rc(`OFS_INT_STATUS, 16'hffff, 16'h0005);
        rc(`OFS_STATUS, 16'h0400, 16'h0400);
    endtask
    // i bits 2:1 are the two load options, bit 0 the word's low bit
    task automatic s_sync();
        logic [15:0] d;
        for (int i = 0; i < 8; i++) begin
            d = 16'h5a00 | 16'(i);
            acc(1'b1, `OFS_CONFIG, 16'h0140 | 16'(i & 6));
            i_bc.msg(cw(5'h05, 1'b1, `MC_SYNC), 1'b0, 1'b0, 1, d);
            tx_chk(1, 16'h2800, 16'h0000);
            if ((i[1] && !i[0]) || (i[2] && i[0])) tt = d;
            rc(`OFS_TIMETAG, 16'hffff, tt);
            rc(pps ? `OFS_BUF_SYNC1 : `OFS_BUF_SYNC0, 16'hffff, d);
            pps = ~pps;
            rc(`OFS_DESC_SYNC, 16'hffff, {13'h0, pps, 2'b00});
            rc(`OFS_INFO_SYNC, 16'hffff, 16'h0000);
            rc(`OFS_INT_STATUS, 16'hffff, 16'h0001);
        end
        tt_tick <= 1'b1;
        repeat (3) @(posedge clk);
        tt_tick <= 1'b0;
        tt = tt + 16'h0003;
        rc(`OFS_TIMETAG, 16'hffff, tt);
        acc(1'b1, `OFS_CONFIG, 16'h0148);
        i_bc.msg(cw(5'h05, 1'b1, `MC_SYNC), 1'b0, 1'b0, 1, 16'h7777);
        tx_chk(1, 16'h2800, 16'h0000);
        rc(`OFS_WORD4_SYNC, 16'hffff, 16'h7777);
        rc(`OFS_TIMETAG, 16'hffff, tt);
        i_bc.msg(cw(`BROADCAST_DESCRIPTOR_FLAG_ADDR, 1'b1, `MC_SYNC), 1'b0, 1'b0, 1, 16'h0246);
        tx_chk(0, 16'h0000, 16'h0000);
        rc(`OFS_STATUS, 16'h0410, 16'h0010);
        acc(1'b1, `OFS_CONFIG, 16'h0160);
        i_bc.msg(cw(5'h05, 1'b0, `MC_SYNC), 1'b0, 1'b0, 0, 16'h0000);
        tx_chk(1, 16'h2c00, 16'h0000);
    endtask
    // --------------------------------
    // clock, watchdog, main sequence
    // --------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        rst_n = 1'b0;
        {adr, rd_en, wr_en, wdat, tt_tick, ppv, pps, tt} = '0;
        error_cnt = 0;
        total_checks = 0;
        cyc = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        s_regs();
        s_vec();
        s_vbc();
        s_ign();
        s_rxd();
        s_vex();
        s_sync();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
